// File: core/ncoc_ctrl_regs.sv
// Control register bank with Avalon-MM slave and oscillator output stage.
//
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - Top bit enables oscillator, readable and writable
// - Bit five reads live output, ignores writes
// - Polarity bit four inverts final output
// - Bits six, three to one read zero
// - Mode bit set selects pulse frequency
// - Any reset clears all control bits
// - Pulse active after carry, for selected periods
// - Polarity change raises interrupt when enabled
module ncoc_ctrl_regs
	import ncoc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic accumulator_carry_out,
	output logic osc_out,
	output logic polarity_change_pulse
);

	// ********************************************************
	// Bus request decode
	// ********************************************************
	ncoc_av_req_s req;
	logic ack_r;
	logic [31:0] rdata_r;
	logic osc_enable_r;
	logic osc_output_invert_r;
	logic pulse_freq_mode_select_r;
	logic [2:0] pulse_width_r;
	logic pol_evt_r;
	ncoc_ctrl_s ctrl;
	logic osc_output_level;

	assign req = '{avs_address, avs_read, avs_write, avs_writedata,
		avs_byteenable};

	// Requests are answered one cycle after they appear.
	wire logic req_live = (req.read | req.write) & ~ack_r;
	wire logic wr_take = req.write & ack_r;
	wire logic hit_ctrl = (req.address == NCOC_CTRL_OFS);
	wire logic hit_pw = (req.address == NCOC_PW_OFS);
	wire logic wr_ctrl = wr_take & hit_ctrl & req.byteenable[0];
	wire logic wr_pw = wr_take & hit_pw & req.byteenable[0];
	wire logic new_pol = req.writedata[NCOC_INV_BIT];

	// Read view of the control register; unused bits fixed at zero.
	wire logic [7:0] ctrl_view = {osc_enable_r, 1'b0,
		osc_output_level, osc_output_invert_r, 3'b000,
		pulse_freq_mode_select_r};

	// Read multiplexer with zero for unmapped addresses.
	wire logic [31:0] rd_mux = hit_ctrl ? {24'h00_0000, ctrl_view} :
		hit_pw ? {29'h0000_0000, pulse_width_r} : NCOC_UNMAPPED_RD;

	// ********************************************************
	// Bus handshake
	// ********************************************************
	// Wait is released in the cycle after a request is seen.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			ack_r <= req_live;
			rdata_r <= req.read ? rd_mux : rdata_r;
		end
	end

	assign avs_waitrequest = (req.read | req.write) & ~ack_r;
	assign avs_readdata = rdata_r;

	// ********************************************************
	// Control register
	// ********************************************************
	// Writable fields; reset clears all of them.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			osc_enable_r <= NCOC_CTRL_RST[NCOC_EN_BIT];
			osc_output_invert_r <= NCOC_CTRL_RST[NCOC_INV_BIT];
			pulse_freq_mode_select_r <= NCOC_CTRL_RST[NCOC_PFM_BIT];
			pulse_width_r <= NCOC_PW_RST;
		end else begin
			if (wr_ctrl) begin
				osc_enable_r <= req.writedata[NCOC_EN_BIT];
				osc_output_invert_r <= new_pol;
				pulse_freq_mode_select_r <= req.writedata[NCOC_PFM_BIT];
			end
			if (wr_pw)
				pulse_width_r <= req.writedata[2:0];
		end
	end

	// Polarity change while enabled flags an output transition.
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			pol_evt_r <= 1'b0;
		else
			pol_evt_r <= wr_ctrl & osc_enable_r &
				(new_pol != osc_output_invert_r);
	end
	assign polarity_change_pulse = pol_evt_r;

	// ********************************************************
	// Oscillator output stage
	// ********************************************************
	assign ctrl = '{osc_enable_r, osc_output_invert_r,
		pulse_freq_mode_select_r, pulse_width_r};

	ncoc_output_stage u_stage (
		.clk(clk),
		.rst(rst),
		.ctrl(ctrl),
		.accumulator_carry_out(accumulator_carry_out),
		.osc_out(osc_output_level)
	);

	assign osc_out = osc_output_level;

	// ********************************************************
	// Checks
	// ********************************************************
	// Pulse tracking for the checks: edges since the last carry and the
	// width loaded with it. A control write stops the tracking, since a
	// mode or polarity change in mid-pulse leaves no clean pulse to time.
	logic [3:0] pulse_age_r;
	logic [2:0] pw_snap_r;
	wire logic pfm_on = osc_enable_r & pulse_freq_mode_select_r;
	wire logic [3:0] pw_len = {1'b0, pw_snap_r} + 4'h1;

	// Age counter saturates so that a long idle gap cannot wrap it.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pulse_age_r <= 4'h0;
			pw_snap_r <= 3'h0;
		end else if (wr_ctrl) begin
			pulse_age_r <= 4'h0;
		end else if (accumulator_carry_out) begin
			pulse_age_r <= 4'h1;
			pw_snap_r <= pulse_width_r;
		end else if (pulse_age_r != 4'h0 && pulse_age_r != 4'hf) begin
			pulse_age_r <= pulse_age_r + 4'h1;
		end
	end

	// A control write that flips the polarity while enabled.
	sequence s_wr_pol_flip;
		wr_ctrl && osc_enable_r && (new_pol != osc_output_invert_r);
	endsequence

	// The change event lasts exactly one cycle.
	sequence s_pol_pulse;
		polarity_change_pulse ##1 !polarity_change_pulse;
	endsequence

	// A carry in fixed-duty mode with no control write beside it.
	sequence s_fdc_carry;
		osc_enable_r && !pulse_freq_mode_select_r && accumulator_carry_out
		&& !wr_ctrl;
	endsequence

	// A carry in pulse mode with no control write beside it.
	sequence s_pfm_carry;
		pfm_on && accumulator_carry_out && !wr_ctrl;
	endsequence

	// Enable bit follows writes and holds otherwise.
	chk_enable_write: assert property (@(posedge clk) disable iff (rst)
		wr_ctrl |=> osc_enable_r == $past(req.writedata[NCOC_EN_BIT]))
		else $error("enable bit did not take written value");
	chk_enable_hold: assert property (@(posedge clk) disable iff (rst)
		!wr_ctrl |=> $stable(osc_enable_r))
		else $error("enable bit changed without a write");

	// Status bit returns the live output level.
	chk_level_readback: assert property (@(posedge clk) disable iff (rst)
		req.read && ack_r && hit_ctrl |=>
		avs_readdata[NCOC_LVL_BIT] == $past(osc_output_level))
		else $error("level bit does not show output");

	// Polarity bit follows writes and sets the idle level.
	chk_invert_write: assert property (@(posedge clk) disable iff (rst)
		wr_ctrl |=> osc_output_invert_r == $past(new_pol))
		else $error("polarity bit did not take written value");
	chk_invert_output: assert property (@(posedge clk) disable iff (rst)
		!osc_enable_r && $past(!osc_enable_r) |->
		osc_out == osc_output_invert_r)
		else $error("idle output ignores polarity");

	// Unimplemented positions always read as zero.
	chk_unused_zero: assert property (@(posedge clk) disable iff (rst)
		avs_readdata[6] == 1'b0 && avs_readdata[3:1] == 3'b000)
		else $error("unimplemented bits read nonzero");

	// Mode bit follows writes; fixed-duty mode toggles only on a carry.
	chk_mode_write: assert property (@(posedge clk) disable iff (rst)
		wr_ctrl |=> pulse_freq_mode_select_r ==
		$past(req.writedata[NCOC_PFM_BIT]))
		else $error("mode bit did not take written value");
	chk_fdc_toggle: assert property (@(posedge clk) disable iff (rst)
		s_fdc_carry |=> $changed(osc_out))
		else $error("fixed duty mode missed toggle");
	chk_fdc_hold: assert property (@(posedge clk) disable iff (rst)
		osc_enable_r && !pulse_freq_mode_select_r && !accumulator_carry_out
		&& !wr_ctrl |=> $stable(osc_out))
		else $error("fixed duty output moved without carry");

	// Reset clears the control bits, the width and the outputs.
	chk_reset_clear: assert property (@(posedge clk)
		$fell(rst) |-> !osc_enable_r && !osc_output_invert_r &&
		!pulse_freq_mode_select_r)
		else $error("control bits not cleared by reset");
	chk_reset_outputs: assert property (@(posedge clk)
		$fell(rst) |-> osc_out == 1'b0 && avs_readdata == 32'h0000_0000 &&
		pulse_width_r == NCOC_PW_RST)
		else $error("outputs not cleared by reset");

	// Pulse starts after a carry, lasts the loaded width plus one, then ends.
	chk_pulse_start: assert property (@(posedge clk) disable iff (rst)
		s_pfm_carry |=> osc_out != osc_output_invert_r)
		else $error("pulse not active after carry");
	chk_pulse_hold: assert property (@(posedge clk) disable iff (rst)
		pfm_on && pulse_age_r != 4'h0 && pulse_age_r <= pw_len |->
		osc_out != osc_output_invert_r)
		else $error("pulse ended before its width");
	chk_pulse_end: assert property (@(posedge clk) disable iff (rst)
		pfm_on && pulse_age_r > pw_len |->
		osc_out == osc_output_invert_r)
		else $error("pulse lasted beyond its width");

	// Change event appears once per flip, and never on its own.
	chk_pol_event: assert property (@(posedge clk) disable iff (rst)
		s_wr_pol_flip |=> s_pol_pulse)
		else $error("polarity change event missing");
	chk_pol_quiet: assert property (@(posedge clk) disable iff (rst)
		polarity_change_pulse |-> $past(wr_ctrl) && $past(osc_enable_r))
		else $error("polarity change event without a write");

endmodule : ncoc_ctrl_regs

// File: core/ncoc_pkg.sv
// Package with register layout, reset values and carrier types of the block.
package ncoc_pkg;

	// ********************************************************
	// Register map and field layout
	// ********************************************************
	localparam logic [3:0] NCOC_CTRL_OFS = 4'h0;
	localparam logic [3:0] NCOC_PW_OFS = 4'h4;
	localparam int NCOC_EN_BIT = 7;
	localparam int NCOC_LVL_BIT = 5;
	localparam int NCOC_INV_BIT = 4;
	localparam int NCOC_PFM_BIT = 0;
	localparam logic [7:0] NCOC_CTRL_RST = 8'h00;
	localparam logic [2:0] NCOC_PW_RST = 3'h0;
	localparam logic [31:0] NCOC_UNMAPPED_RD = 32'h0000_0000;

	// Control fields as seen by the oscillator datapath.
	typedef struct packed {
		logic enable;
		logic invert;
		logic pfm;
		logic [2:0] pulse_width;
	} ncoc_ctrl_s;

	// Avalon-MM request from the bus master.
	typedef struct packed {
		logic [3:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} ncoc_av_req_s;

endpackage : ncoc_pkg

// File: core/ncoc_output_stage.sv
// Output shaping stage: toggle or pulse stretch, then polarity.
`timescale 1ns/1ps
module ncoc_output_stage
	import ncoc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire ncoc_ctrl_s ctrl,
	input wire logic accumulator_carry_out,
	output logic osc_out
);

	// ********************************************************
	// Raw output state
	// ********************************************************
	logic raw_r;
	logic raw_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	wire logic [3:0] width = {1'b0, ctrl.pulse_width} + 4'h1;

	// Toggle on carry, or hold active for pw+1 periods after carry.
	always_comb begin
		raw_nxt = raw_r;
		cnt_nxt = cnt_r;
		if (!ctrl.enable) begin
			raw_nxt = 1'b0;
			cnt_nxt = 4'h0;
		end else if (!ctrl.pfm) begin
			if (accumulator_carry_out)
				raw_nxt = ~raw_r;
		end else if (accumulator_carry_out) begin
			raw_nxt = 1'b1;
			cnt_nxt = width;
		end else if (cnt_r > 4'h1) begin
			cnt_nxt = cnt_r - 4'h1;
		end else begin
			raw_nxt = 1'b0;
			cnt_nxt = 4'h0;
		end
	end

	// State registers, cleared on reset.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			raw_r <= 1'b0;
			cnt_r <= 4'h0;
		end else begin
			raw_r <= raw_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Final polarity stage.
	assign osc_out = raw_r ^ ctrl.invert;

endmodule : ncoc_output_stage

// File: test/nco_control_register_bench.sv
// Self-checking bench for the oscillator control register bank.
`timescale 1ns/1ps
module nco_control_register_bench;
	import ncoc_pkg::*;
	logic clk = 0, rst = 1, avs_read = 0, avs_write = 0, carry = 0;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rnd = 32'h4889;
	logic avs_waitrequest, osc_out, pol_pulse;
	logic [31:0] exp_q[$];
	int fails = 0, comparisons = 0, cyc = 0, hi, pcnt = 0, p0;
	// ********************************************************
	// Clock, device and timeout
	// ********************************************************
	always #4 clk = ~clk;
	ncoc_ctrl_regs uut (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.accumulator_carry_out(carry), .osc_out(osc_out),
		.polarity_change_pulse(pol_pulse));
	// Counts cycles, cuts a hang short and counts change pulses.
	always @(posedge clk) begin
		cyc++;
		pcnt <= pcnt + (pol_pulse === 1'b1);
		if (cyc > 3000) begin
			fails++;
			stop_test();
		end
	end
	// Compares each completed read with the oldest expected value.
	always @(posedge clk) begin
		if (avs_read && avs_waitrequest === 1'b0) begin
			check("readdata", avs_readdata, exp_q.pop_front());
		end
	end
	// ********************************************************
	// Tasks
	// ********************************************************
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs
	task check(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task stop_test();
		$display("checks %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	// Holds one request until waitrequest is seen low, then releases it.
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask : bus
	task rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0, 4'hf);
	endtask : rd
	task pulse();
		carry <= 1'b1;
		@(posedge clk);
		carry <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : pulse
	// ********************************************************
	// Main sequence
	// ********************************************************
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(NCOC_CTRL_OFS, 32'h0);
		rd(NCOC_PW_OFS, 32'h0);
		bus(1'b1, NCOC_CTRL_OFS, 32'hff, 4'hf);
		rd(NCOC_CTRL_OFS, 32'hb1);
		bus(1'b1, NCOC_CTRL_OFS, 32'h0, 4'h0);
		rd(NCOC_CTRL_OFS, 32'hb1);
		bus(1'b1, 4'h8, 32'hff, 4'hf);
		rd(4'h8, 32'h0);
		$display("test access done");
		for (int i = 0; i < 8; i++) begin
			rnd = xs(rnd);
			bus(1'b1, NCOC_CTRL_OFS, rnd, 4'hf);
			rd(NCOC_CTRL_OFS, {24'h0, rnd[7], 1'b0, rnd[4], rnd[4], 3'h0,
				rnd[0]});
		end
		$display("test random done");
		bus(1'b1, NCOC_CTRL_OFS, 32'h80, 4'hf);
		pulse();
		rd(NCOC_CTRL_OFS, 32'ha0);
		pulse();
		rd(NCOC_CTRL_OFS, 32'h80);
		p0 = pcnt;
		bus(1'b1, NCOC_CTRL_OFS, 32'h90, 4'hf);
		@(posedge clk);
		check("pol_pulse", pcnt - p0, 32'h1);
		$display("test toggle done");
		rnd = xs(rnd);
		bus(1'b1, NCOC_PW_OFS, {29'h0, rnd[2:0]}, 4'hf);
		bus(1'b1, NCOC_CTRL_OFS, 32'h81, 4'hf);
		hi = 0;
		carry <= 1'b1;
		@(posedge clk);
		carry <= 1'b0;
		repeat (12) @(posedge clk) hi += (osc_out === 1'b1);
		check("pulse_len", hi, rnd[2:0] + 32'h1);
		$display("test pulse done");
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(NCOC_CTRL_OFS, 32'h0);
		rd(NCOC_PW_OFS, 32'h0);
		$display("test reset again done");
		stop_test();
	end
endmodule : nco_control_register_bench
